// [pkg/lcsi_pkg.sv]
`default_nettype none
package lcsi_pkg;
  // clock and time base
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned MS_CNT_W = 16;

  // display times, in milliseconds of the time base
  localparam logic [15:0] FLASH_HALF_MS = 16'h00FA;
  localparam int unsigned ALIGN_LONG_S = 3;
  localparam logic [15:0] ALIGN_LONG_MS = 16'(ALIGN_LONG_S * MS_PER_S);
  localparam logic [15:0] PRESS_SHOW_MS = 16'h01F4;
  localparam logic [15:0] RESET_STUCK_MS = 16'h1388;
  localparam logic [15:0] FB_LOSS_MS = 16'h0064;
  localparam logic [15:0] QUAL_HOLD_MS = 16'h2710;

  // register offsets (byte addresses)
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_CONTROL = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0C;
  localparam logic [7:0] OFS_STATE = 8'h10;

  // config register fields
  localparam int unsigned CFG_FBM = 0;
  localparam int unsigned CFG_CODE_LO = 1;
  localparam int unsigned CFG_RIL = 3;
  localparam int unsigned CFG_W = 4;
  localparam logic [3:0] CFG_RESET = 4'h0;

  // control register fields
  localparam int unsigned CTL_SHOW_CFG = 0;
  localparam int unsigned CTL_FACTORY = 1;
  localparam int unsigned CTL_EXIT_CFG = 2;
  localparam logic [1:0] CTL_RESET = 2'h0;

  // event status / mask fields
  localparam int unsigned EV_CFG_MODE = 0;
  localparam int unsigned EV_RST_FAULT = 1;
  localparam int unsigned EV_FB_WARN = 2;
  localparam int unsigned EV_CONTAM_HI = 3;
  localparam int unsigned EV_FIELD_INT = 4;
  localparam int unsigned EV_W = 5;
  localparam logic [4:0] EV_RESET = 5'h00;

  // contamination levels
  localparam logic [1:0] CONTAM_WEAK = 2'h1;
  localparam logic [1:0] CONTAM_HIGH = 2'h2;

  // led colours
  localparam int unsigned COL_W = 3;
  localparam int unsigned DIAG_N = 8;
  typedef enum logic [2:0] {
    COL_OFF, COL_RED, COL_GREEN, COL_YELLOW, COL_YELLOW_GREEN, COL_WHITE, COL_BLUE
  } lcsi_colour_t;
endpackage
`default_nettype wire

// [src/lcsi_sync3.sv]
`default_nettype none
module lcsi_sync3 #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // asynchronous pins and their settled value
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, level_reg;
  logic [WIDTH-1:0] level_next;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("lcsi_sync3 needs WIDTH of at least 1");
    end
  endgenerate

  // a bit changes only once the second and third stages agree
  always_comb begin
    level_next = level_reg;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        level_next[i] = s2_reg[i];
      end
    end
  end

  // the first stage feeds only the second, to keep metastability contained
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      level_reg <= '0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign level_out = level_reg;
endmodule
`default_nettype wire

// [src/lcsi_timebase.sv]
`default_nettype none
module lcsi_timebase
  import lcsi_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // millisecond enable and common flash phase
  output logic ms_tick_out,
  output logic flash_on_out
);
  localparam int unsigned DIV_W = $clog2(MS_CYC + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYC - 1);

  logic [DIV_W-1:0] div_reg, div_next;
  logic [15:0] half_reg, half_next;
  logic tick_reg, tick_next;
  logic flash_reg, flash_next;

  generate
    if (MS_CYC < 2) begin : g_chk
      $error("lcsi_timebase needs MS_CYC of at least 2");
    end
  endgenerate

  // one divider for all flashing, so every flashing led toggles in phase
  always_comb begin
    div_next = div_reg + DIV_W'(1);
    tick_next = 1'b0;
    half_next = half_reg;
    flash_next = flash_reg;
    if (div_reg == DIV_LAST) begin
      div_next = '0;
      tick_next = 1'b1;
    end
    if (tick_reg) begin
      half_next = half_reg + 16'h0001;
      if (half_reg == FLASH_HALF_MS - 16'h0001) begin
        half_next = '0;
        flash_next = ~flash_reg;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      div_reg <= '0;
      half_reg <= '0;
      tick_reg <= 1'b0;
      flash_reg <= 1'b1;
    end else begin
      div_reg <= div_next;
      half_reg <= half_next;
      tick_reg <= tick_next;
      flash_reg <= flash_next;
    end
  end

  assign ms_tick_out = tick_reg;
  assign flash_on_out = flash_reg;
endmodule
`default_nettype wire

// [src/lcsi_top.sv]
// What this block does
// - config view: led1 white if feedback monitor, led3 coding 1/2, led4 interlock
// - factory reset: output red, field yellow/green, all diagnostic leds off
// - any configuration change enters config mode: output red, field green
// - laser alignment aid on with clear field: field green; the output led still follows the outputs
// - field interrupted: output and field red; clear with reset just pressed: field red
// - field clear but reset pending: output red, field yellow
// - reset button faulty or held continuously: diagnostic led4 flashes yellow
// - no feedback signal: warning, output red, diagnostic led1 flashes yellow
// - quality display resumes on contamination rise, laser on, alignment over 3 s
// - weak signal from contamination lights diagnostic leds 1 and 2 while the quality display is off
// - high contamination switches the safety outputs off
// - quality shows zero to four blue leds; 5,6 top beam, 7,8 bottom beam
// - feedback warning flashes led1, reset fault led4; others keep showing quality
`default_nettype none
module lcsi_top
  import lcsi_pkg::*;
#(
  parameter int unsigned MS_CYC = MS_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // receiver conditions, same clock
  input wire logic field_interrupted_in,
  input wire logic laser_aid_on_in,
  input wire logic reset_pending_in,
  input wire logic [2:0] quality_level_in,
  input wire logic top_beam_sync_in,
  input wire logic bottom_beam_sync_in,
  input wire logic [1:0] contamination_level_in,
  input wire logic aligning_in,
  // pins from outside
  input wire logic reset_button_pin_in,
  input wire logic contactor_feedback_monitor_pin_in,
  // indicators and outputs
  output lcsi_colour_t output_led_out,
  output lcsi_colour_t field_led_out,
  output logic [DIAG_N*COL_W-1:0] diag_led_out,
  output logic safety_switching_output_on_out,
  output logic irq_out
);
  logic ms_tick, flash_on, button, feedback;
  logic [CFG_W-1:0] cfg_reg, cfg_next;
  logic [1:0] ctl_reg, ctl_next;
  logic [EV_W-1:0] status_reg, status_next, mask_reg, mask_next, snap_reg, snap_next, ev_set;
  logic [31:0] rdata_reg, rdata_next;
  logic cfg_mode_reg, cfg_mode_next, qual_reg, qual_next;
  logic fb_warn_reg, fb_warn_next, button_reg, field_reg, laser_reg;
  logic rst_fault_d_reg, contam_hi_d_reg;
  logic [1:0] contam_reg;
  logic [15:0] press_reg, press_next, stuck_reg, stuck_next, fb_reg, fb_next;
  logic [15:0] align_reg, align_next, hold_reg, hold_next;
  lcsi_colour_t out_led_reg, out_led_next, field_led_reg, field_led_next;
  logic [DIAG_N*COL_W-1:0] diag_reg, diag_next;
  logic sso_reg, sso_next;
  logic setup, wr_acc, rd_acc, mapped, rst_fault, contam_hi, press_show;

  lcsi_timebase #(.MS_CYC(MS_CYC)) u_timebase (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .ms_tick_out(ms_tick),
    .flash_on_out(flash_on)
  );

  lcsi_sync3 #(.WIDTH(2)) u_sync (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .pin_in({reset_button_pin_in, contactor_feedback_monitor_pin_in}),
    .level_out({button, feedback})
  );

  // saturating millisecond counter, cleared while not running
  function automatic logic [15:0] ms_count(input logic [15:0] cnt, input logic run,
                                           input logic tick, input logic [15:0] lim);
    ms_count = cnt;
    if (!run) begin
      ms_count = '0;
    end else if (tick && cnt < lim) begin
      ms_count = cnt + 16'h0001;
    end
  endfunction

  // places one colour on one diagnostic led
  function automatic logic [DIAG_N*COL_W-1:0] put_led(input logic [DIAG_N*COL_W-1:0] v,
                                                      input int unsigned idx,
                                                      input lcsi_colour_t c);
    put_led = v;
    put_led[idx*COL_W +: COL_W] = c;
  endfunction

  // bus decode; the slave never waits, so the access phase is its answer
  always_comb begin
    setup = psel_in && !penable_in;
    wr_acc = psel_in && penable_in && pwrite_in;
    rd_acc = psel_in && penable_in && !pwrite_in;
    mapped = (paddr_in == OFS_CONFIG) || (paddr_in == OFS_CONTROL)
          || (paddr_in == OFS_STATUS) || (paddr_in == OFS_MASK)
          || (paddr_in == OFS_STATE);
  end

  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !mapped;
  assign prdata_out = rdata_reg;

  // derived fault levels
  always_comb begin
    rst_fault = stuck_reg >= RESET_STUCK_MS;
    contam_hi = contamination_level_in >= CONTAM_HIGH;
    press_show = press_reg != 16'h0000;
  end

  // registers and events; read data is captured at setup and shown in access
  always_comb begin
    cfg_next = cfg_reg;
    ctl_next = ctl_reg;
    mask_next = mask_reg;
    cfg_mode_next = cfg_mode_reg;
    rdata_next = rdata_reg;
    snap_next = snap_reg;
    if (wr_acc && paddr_in == OFS_CONFIG) begin
      cfg_next = pwdata_in[CFG_W-1:0];
      cfg_mode_next = 1'b1;
    end else if (wr_acc && paddr_in == OFS_CONTROL) begin
      ctl_next = pwdata_in[CTL_FACTORY:CTL_SHOW_CFG];
      if (pwdata_in[CTL_EXIT_CFG]) begin
        cfg_mode_next = 1'b0;
      end
    end
    if (wr_acc && paddr_in == OFS_MASK) begin
      mask_next = pwdata_in[EV_W-1:0];
    end
    if (setup) begin
      snap_next = '0;
      unique case (paddr_in)
        OFS_CONFIG: rdata_next = 32'(cfg_reg);
        OFS_CONTROL: rdata_next = 32'(ctl_reg);
        OFS_STATUS: begin
          rdata_next = 32'(status_reg);
          snap_next = status_reg;
        end
        OFS_MASK: rdata_next = 32'(mask_reg);
        OFS_STATE: rdata_next = 32'({qual_reg, sso_reg, fb_warn_reg, rst_fault, cfg_mode_reg});
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    ev_set = '0;
    ev_set[EV_CFG_MODE] = cfg_mode_next && !cfg_mode_reg;
    ev_set[EV_RST_FAULT] = rst_fault && !rst_fault_d_reg;
    ev_set[EV_FB_WARN] = fb_warn_next && !fb_warn_reg;
    ev_set[EV_CONTAM_HI] = contam_hi && !contam_hi_d_reg;
    ev_set[EV_FIELD_INT] = field_interrupted_in && !field_reg;
    // only bits seen by the read are cleared, and a new event beats the clear
    status_next = status_reg;
    if (rd_acc && paddr_in == OFS_STATUS) begin
      status_next = status_reg & ~snap_reg;
    end
    status_next = status_next | ev_set;
  end

  // supervision timers on the millisecond enable
  always_comb begin
    press_next = press_reg;
    if (button && !button_reg) begin
      press_next = PRESS_SHOW_MS;
    end else if (ms_tick && press_show) begin
      press_next = press_reg - 16'h0001;
    end
    stuck_next = ms_count(stuck_reg, button, ms_tick, RESET_STUCK_MS);
    fb_next = ms_count(fb_reg, cfg_reg[CFG_FBM] && !feedback, ms_tick, FB_LOSS_MS);
    // warning holds until power is cycled
    fb_warn_next = fb_warn_reg || (cfg_reg[CFG_FBM] && fb_reg >= FB_LOSS_MS);
    align_next = ms_count(align_reg, aligning_in, ms_tick, ALIGN_LONG_MS);
    hold_next = ms_count(hold_reg, qual_reg && !field_interrupted_in && !aligning_in,
                         ms_tick, QUAL_HOLD_MS);
    qual_next = qual_reg;
    if (qual_reg && hold_reg >= QUAL_HOLD_MS) begin
      qual_next = 1'b0;
    end
    if (contamination_level_in > contam_reg || (laser_aid_on_in && !laser_reg)
        || align_reg >= ALIGN_LONG_MS) begin
      qual_next = 1'b1;
    end
  end

  // display priority: factory, config mode, faults, field state, quality
  always_comb begin
    sso_next = !field_interrupted_in && !reset_pending_in && !contam_hi
            && !fb_warn_reg && !ctl_reg[CTL_FACTORY] && !cfg_mode_reg;
    out_led_next = sso_next ? COL_GREEN : COL_RED;
    diag_next = '0;
    if (ctl_reg[CTL_FACTORY]) begin
      field_led_next = COL_YELLOW_GREEN;
    end else if (cfg_mode_reg) begin
      field_led_next = COL_GREEN;
    end else if (field_interrupted_in || press_show) begin
      field_led_next = COL_RED;
    end else if (laser_aid_on_in) begin
      field_led_next = COL_GREEN;
    end else if (reset_pending_in) begin
      field_led_next = COL_YELLOW;
    end else begin
      field_led_next = COL_GREEN;
    end
    if (ctl_reg[CTL_FACTORY]) begin
      diag_next = '0;
    end else if (ctl_reg[CTL_SHOW_CFG]) begin
      if (cfg_reg[CFG_FBM]) begin
        diag_next = put_led(diag_next, 0, COL_WHITE);
      end
      if (cfg_reg[CFG_CODE_LO +: 2] != 2'h0) begin
        diag_next = put_led(diag_next, 2, COL_WHITE);
      end
      if (cfg_reg[CFG_RIL]) begin
        diag_next = put_led(diag_next, 3, COL_WHITE);
      end
    end else begin
      if (qual_reg) begin
        for (int unsigned i = 0; i < 4; i++) begin
          if (quality_level_in > 3'(i)) begin
            diag_next = put_led(diag_next, i, COL_BLUE);
          end
        end
        if (top_beam_sync_in) begin
          diag_next = put_led(diag_next, 4, COL_BLUE);
          diag_next = put_led(diag_next, 5, COL_BLUE);
        end
        if (bottom_beam_sync_in) begin
          diag_next = put_led(diag_next, 6, COL_BLUE);
          diag_next = put_led(diag_next, 7, COL_BLUE);
        end
      end else if (contamination_level_in >= CONTAM_WEAK) begin
        // weak signal shows as two quality bars
        diag_next = put_led(diag_next, 0, COL_BLUE);
        diag_next = put_led(diag_next, 1, COL_BLUE);
      end
      // fault leds flash over the quality, the rest keep their meaning
      if (fb_warn_reg) begin
        diag_next = put_led(diag_next, 0, flash_on ? COL_YELLOW : COL_OFF);
      end
      if (rst_fault) begin
        diag_next = put_led(diag_next, 3, flash_on ? COL_YELLOW : COL_OFF);
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cfg_reg <= CFG_RESET;
      ctl_reg <= CTL_RESET;
      status_reg <= EV_RESET;
      mask_reg <= EV_RESET;
      snap_reg <= EV_RESET;
      rdata_reg <= 32'h0000_0000;
      cfg_mode_reg <= 1'b0;
      qual_reg <= 1'b1;
      fb_warn_reg <= 1'b0;
      button_reg <= 1'b0;
      field_reg <= 1'b0;
      laser_reg <= 1'b0;
      rst_fault_d_reg <= 1'b0;
      contam_hi_d_reg <= 1'b0;
      contam_reg <= 2'h0;
      press_reg <= 16'h0000;
      stuck_reg <= 16'h0000;
      fb_reg <= 16'h0000;
      align_reg <= 16'h0000;
      hold_reg <= 16'h0000;
      out_led_reg <= COL_RED;
      field_led_reg <= COL_RED;
      diag_reg <= '0;
      sso_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      ctl_reg <= ctl_next;
      status_reg <= status_next;
      mask_reg <= mask_next;
      snap_reg <= snap_next;
      rdata_reg <= rdata_next;
      cfg_mode_reg <= cfg_mode_next;
      qual_reg <= qual_next;
      fb_warn_reg <= fb_warn_next;
      button_reg <= button;
      field_reg <= field_interrupted_in;
      laser_reg <= laser_aid_on_in;
      rst_fault_d_reg <= rst_fault;
      contam_hi_d_reg <= contam_hi;
      contam_reg <= contamination_level_in;
      press_reg <= press_next;
      stuck_reg <= stuck_next;
      fb_reg <= fb_next;
      align_reg <= align_next;
      hold_reg <= hold_next;
      out_led_reg <= out_led_next;
      field_led_reg <= field_led_next;
      diag_reg <= diag_next;
      sso_reg <= sso_next;
    end
  end

  // outputs straight from flip-flops; irq is the or of the masked status bits
  assign output_led_out = out_led_reg;
  assign field_led_out = field_led_reg;
  assign diag_led_out = diag_reg;
  assign safety_switching_output_on_out = sso_reg;
  assign irq_out = |(status_reg & mask_reg);
endmodule
`default_nettype wire

// [verification/lcsi_chk_assertions.sv]
`default_nettype none
module lcsi_chk
  import lcsi_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // bus handshake
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pslverr_out,
  // receiver conditions
  input wire logic field_interrupted_in,
  input wire logic reset_pending_in,
  input wire logic [1:0] contamination_level_in,
  // indicators
  input wire lcsi_colour_t output_led_out,
  input wire lcsi_colour_t field_led_out,
  input wire logic [DIAG_N*COL_W-1:0] diag_led_out,
  input wire logic safety_switching_output_on_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  // named steps of the bus and display behaviour
  sequence s_access;
    psel_in && penable_in;
  endsequence
  sequence s_factory;
    field_led_out == COL_YELLOW_GREEN;
  endsequence
  // an on phase entered from the off phase is whole unless the factory or config view begins during it
  sequence s_led1_yellow;
    $past(diag_led_out[2:0]) == COL_OFF && diag_led_out[2:0] == COL_YELLOW;
  endsequence
  // bus error only while a transfer is in its access phase
  AST_ERR_PHASE: assert property (pslverr_out |-> s_access)
    else $error("slave error outside access phase");
  AST_FACT_DARK: assert property (s_factory |-> diag_led_out == '0 && output_led_out == COL_RED)
    else $error("factory view not dark");
  AST_FIELD_INT: assert property (field_interrupted_in |=>
    !safety_switching_output_on_out && output_led_out == COL_RED)
    else $error("interrupted field left outputs on");
  AST_FIELD_PRIO: assert property (field_interrupted_in |=>
    field_led_out inside {COL_RED, COL_GREEN, COL_YELLOW_GREEN})
    else $error("interrupted field shows wrong colour");
  AST_PENDING: assert property (reset_pending_in |=> !safety_switching_output_on_out)
    else $error("outputs on with reset pending");
  AST_CONTAM: assert property (contamination_level_in >= CONTAM_HIGH |=>
    !safety_switching_output_on_out)
    else $error("outputs on with high contamination");
  AST_OUT_LED: assert property (output_led_out ==
    (safety_switching_output_on_out ? COL_GREEN : COL_RED))
    else $error("output led disagrees with outputs");
  // a flash phase lasts far longer than eight cycles at any time base
  AST_FLASH: assert property (s_led1_yellow |=> (diag_led_out[2:0] == COL_YELLOW) [*8])
    else $error("flash phase too short");
  // reset state is checked straight after each reset edge, so it ignores the disable
  AST_RESET: assert property (disable iff (1'b0) reset_in |=> output_led_out == COL_RED &&
    field_led_out == COL_RED && diag_led_out == '0 && !irq_out && !safety_switching_output_on_out)
    else $error("wrong state after reset");
endmodule
`default_nettype wire

// [verification/lcsi_pin_model.sv]
`default_nettype none
module lcsi_pin_model (
  // clock
  input wire logic ref_clk_in,
  // operator and contactor commands
  input wire logic press_in,
  input wire logic fb_lost_in,
  // pins toward the receiver
  output logic reset_button_pin_out = 1'b0,
  output logic feedback_pin_out = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;
  // one clock of lag stands in for slow mechanics; the receiver syncs the pins anyway
  always @(posedge ref_clk_in) begin
    reset_button_pin_out <= press_in;
    feedback_pin_out <= !fb_lost_in; // high while the contactor signal is present
  end
endmodule
`default_nettype wire

// [verification/test_light_curtain_status_indicator.sv]
`default_nettype none
module test_light_curtain_status_indicator;
  import lcsi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned MSC = 4;
  localparam int LIMIT = 40000;
  localparam logic [31:0] CFGS [3] = '{32'h0000000B, 32'h00000004, 32'h00000001};
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, e;
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h00000000, prd, q;
  logic prdy, perr, sso, irq, bpin, fpin;
  logic fint = 1'b0, laser = 1'b0, pend = 1'b0, topb = 1'b0, botb = 1'b0;
  logic press = 1'b0, fblost = 1'b0, align = 1'b0;
  logic [2:0] qual = 3'h0;
  logic [1:0] contam = 2'h0, seen;
  logic [7:0] rnd = 8'h37;
  lcsi_colour_t oled, fled;
  logic [23:0] diag;
  int errors = 0, checks = 0, cyc = 0;
  always #2 clk = ~clk;
  lcsi_pin_model pins (.ref_clk_in(clk), .press_in(press), .fb_lost_in(fblost),
    .reset_button_pin_out(bpin), .feedback_pin_out(fpin));
  lcsi_top #(.MS_CYC(MSC)) dut (.ref_clk_in(clk), .reset_in(rst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(padr), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .field_interrupted_in(fint),
    .laser_aid_on_in(laser), .reset_pending_in(pend), .quality_level_in(qual),
    .top_beam_sync_in(topb), .bottom_beam_sync_in(botb), .contamination_level_in(contam),
    .aligning_in(align), .reset_button_pin_in(bpin), .contactor_feedback_monitor_pin_in(fpin),
    .output_led_out(oled), .field_led_out(fled), .diag_led_out(diag),
    .safety_switching_output_on_out(sso), .irq_out(irq));
  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // comparisons
  task automatic cmp_bits(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_col(input lcsi_colour_t got, input lcsi_colour_t exp);
    cmp_bits(32'(got), 32'(exp));
  endtask
  // wait n edges, then sample half a cycle later where outputs are settled
  task automatic go(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // one bus transfer; the answer is taken on the edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic err);
    logic rdy;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // the answer is taken only at the rising edge that sees pready high
    do begin
      @(posedge clk);
      rdy = prdy;
    end while (rdy !== 1'b1);
    rd = prd;
    err = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000, q, e);
    cmp_bits(q, exp);
  endtask
  // expected displays
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [31:0] bars(input int n, input logic t, input logic b);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 4; i++) begin
      r[i*3+:3] = (i < n) ? COL_BLUE : COL_OFF;
    end
    r[12+:6] = t ? {COL_BLUE, COL_BLUE} : 6'h00;
    r[18+:6] = b ? {COL_BLUE, COL_BLUE} : 6'h00;
    return r;
  endfunction
  function automatic logic [31:0] flags(input logic [31:0] c);
    logic [31:0] r;
    r = '0;
    r[0+:3] = c[0] ? COL_WHITE : COL_OFF;
    r[6+:3] = (c[2:1] != 2'h0) ? COL_WHITE : COL_OFF;
    r[9+:3] = c[3] ? COL_WHITE : COL_OFF;
    return r;
  endfunction
  // a hang counts as a mismatch
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      errors++;
      complete_run();
    end
  end
  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    go(2);
    cmp_col(oled, COL_GREEN);
    cmp_col(fled, COL_GREEN);
    rd_chk(OFS_CONFIG, 32'h00000000);
    rd_chk(OFS_CONTROL, 32'h00000000);
    rd_chk(OFS_MASK, 32'h00000000);
    apb(1'b0, 8'h14, 32'h00000000, q, e);
    cmp_bits({q[30:0], e}, 32'h00000001);
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk);
      qual <= (i < 5) ? 3'(i) : 3'(rnd % 5);
      topb <= rnd[3];
      botb <= rnd[4];
      go(2);
      cmp_bits({8'h00, diag}, bars(int'(qual), topb, botb));
    end
    wr(OFS_MASK, 32'h0000001F);
    @(posedge clk);
    fint <= 1'b1;
    go(2);
    cmp_col(fled, COL_RED);
    cmp_bits({30'h0, sso, irq}, 32'h00000001);
    @(posedge clk);
    fint <= 1'b0;
    rd_chk(OFS_STATUS, 32'h00000010);
    go(1);
    cmp_bits({31'h0, irq}, 32'h00000000);
    @(posedge clk);
    pend <= 1'b1;
    go(2);
    cmp_col(fled, COL_YELLOW);
    cmp_col(oled, COL_RED);
    @(posedge clk);
    laser <= 1'b1;
    go(2);
    cmp_col(fled, COL_GREEN);
    cmp_col(oled, COL_RED);
    @(posedge clk);
    laser <= 1'b0;
    pend <= 1'b0;
    wr(OFS_MASK, 32'h00000010);
    @(posedge clk);
    qual <= 3'h2;
    topb <= 1'b0;
    botb <= 1'b0;
    contam <= CONTAM_WEAK;
    go(2);
    cmp_bits({8'h00, diag}, bars(2, 1'b0, 1'b0));
    @(posedge clk);
    contam <= CONTAM_HIGH;
    go(2);
    cmp_bits({30'h0, sso, irq}, 32'h00000000);
    rd_chk(OFS_STATUS, 32'h00000008);
    @(posedge clk);
    contam <= 2'h0;
    foreach (CFGS[k]) begin
      wr(OFS_CONFIG, CFGS[k]);
      wr(OFS_CONTROL, 32'h00000001);
      go(2);
      cmp_bits({8'h00, diag}, flags(CFGS[k]));
      cmp_col(fled, COL_GREEN);
      cmp_col(oled, COL_RED);
    end
    rd_chk(OFS_STATUS, 32'h00000001);
    wr(OFS_CONTROL, 32'h00000002);
    go(2);
    cmp_col(fled, COL_YELLOW_GREEN);
    cmp_bits({8'h00, diag}, 32'h00000000);
    wr(OFS_CONTROL, 32'h00000004);
    go(2);
    cmp_col(oled, COL_GREEN);
    wr(OFS_MASK, 32'h00000006);
    @(posedge clk);
    fblost <= 1'b1;
    go(420);
    cmp_col(oled, COL_RED);
    // clear the warning event so the next interrupt can only come from the button
    rd_chk(OFS_STATUS, 32'h00000004);
    @(posedge clk);
    press <= 1'b1;
    align <= 1'b1;
    go(20100);
    cmp_bits({31'h0, irq}, 32'h00000001);
    rd_chk(OFS_STATE, 32'h00000016);
    seen = 2'b00;
    // both flashing leds must match in every sample over a little more than one flash period
    repeat (22) begin
      go(100);
      cmp_bits(32'(diag[9+:3]), 32'(diag[0+:3]));
      cmp_bits(32'(diag[3+:3]), 32'(COL_BLUE));
      seen = seen | {diag[2:0] == COL_YELLOW, diag[2:0] == COL_OFF};
    end
    cmp_bits({30'h0, seen}, 32'h00000003);
    rd_chk(OFS_STATUS, 32'h00000002);
    complete_run();
  end
endmodule
bind lcsi_top lcsi_chk chk (.ref_clk_in, .reset_in, .psel_in, .penable_in, .pslverr_out,
  .field_interrupted_in, .reset_pending_in, .contamination_level_in, .output_led_out,
  .field_led_out, .diag_led_out, .safety_switching_output_on_out, .irq_out);
`default_nettype wire
